// >>> include/pmic_supervisor_pkg.sv
// Overview of operation
// - Linear good high when at least one linear rail is enabled and every enabled one regulates
// - Linear good low in OFF and hard reset, follows linear rail health in other states
// - Main good combines bucks, switchables, unmasked linears
// - Main good waits ACTIVE, sequencer done, release delay
// - Load-switch good and overcurrent are ignored
// - Button input deglitched for 50 ms
// - Button press wakes from OFF or SLEEP
// - Button held over 8 s power-cycles device
// - Button changes set flag; level readable
// - Wake pin low on wakeup, released when ACTIVE
// - Wake low 50 ms after event until hold+50 ms
// - No hold within 5 s: power down
// - Power hold sampled as a level
// - Power hold level moves ACTIVE and SLEEP
// - Hard reset: rails off, defaults, at least 1 s
// - Hard reset release enters ACTIVE, sequences up
// - Events set flags and pull interrupt low
// - Flag read clears; persisting conditions re-assert
// - Masks gate only the interrupt pin
// - Events: button press/release, AC/USB changes, faults
// - Source priority AC, then USB, then battery
// - AC-to-USB switch depends on battery condition
// - Good release delay defaults to 20 ms
package pmic_supervisor_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned DEGLITCH_MS = 50;
	localparam int unsigned WAKE_DELAY_MS = 50;
	localparam int unsigned GOOD_RELEASE_MS = 20;
	localparam int unsigned LONG_PRESS_S = 8;
	localparam int unsigned HOLD_TIMEOUT_S = 5;
	localparam int unsigned HARD_RESET_MIN_S = 1;
	localparam int unsigned IRQ_REARM_US = 32;
	localparam int unsigned DEGLITCH_CYCLES = DEGLITCH_MS * (CLK_HZ / 1000);
	localparam int unsigned WAKE_DELAY_CYCLES = WAKE_DELAY_MS * (CLK_HZ / 1000);
	localparam int unsigned GOOD_RELEASE_CYCLES = GOOD_RELEASE_MS * (CLK_HZ / 1000);
	localparam int unsigned LONG_PRESS_CYCLES = LONG_PRESS_S * CLK_HZ;
	localparam int unsigned HOLD_TIMEOUT_CYCLES = HOLD_TIMEOUT_S * CLK_HZ;
	localparam int unsigned HARD_RESET_MIN_CYCLES = HARD_RESET_MIN_S * CLK_HZ;
	localparam logic [11:0] IRQ_REARM_CYCLES = 12'(IRQ_REARM_US * (CLK_HZ / 1_000_000));
	localparam logic [7:0] OFFS_GOOD_MASK_CONFIG = 8'h00;
	localparam logic [7:0] OFFS_CONFIG = 8'h04;
	localparam logic [7:0] OFFS_STATUS = 8'h08;
	localparam logic [7:0] OFFS_IRQ_FLAGS = 8'h0C;
	localparam logic [7:0] OFFS_IRQ_MASK = 8'h10;
	localparam logic [1:0] GOOD_MASK_RESET = 2'h3;
	localparam logic [2:0] CONFIG_RESET = 3'h0;
	localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
	localparam int unsigned CFG_OFF_SELECT = 0;
	localparam int unsigned CFG_SW1_LOAD_SWITCH = 1;
	localparam int unsigned CFG_SW2_LOAD_SWITCH = 2;
	localparam int unsigned IRQ_BUTTON = 0;
	localparam int unsigned IRQ_AC = 1;
	localparam int unsigned IRQ_USB = 2;
	localparam int unsigned IRQ_FAULT = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_SLEEP = 3'b001,
		ST_WAIT_HOLD = 3'b010,
		ST_ACTIVE = 3'b011,
		ST_HARD_RESET = 3'b100,
		ST_CYCLE = 3'b101
	} power_state_t;
	typedef enum logic [1:0] {
		SRC_BATTERY = 2'b00,
		SRC_USB = 2'b01,
		SRC_AC = 2'b10
	} source_t;
	typedef enum logic [1:0] {
		BATT_GOOD = 2'b00,
		BATT_DEAD = 2'b01,
		BATT_SHORT = 2'b10
	} battery_t;
endpackage

// >>> tb/host_model.sv
`timescale 1ns/10ps
module host_model (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic wake_level_n,
	input wire logic [1:0] hold_mode,
	output logic power_hold
);
	int cnt;
	// Mode 0 drops hold, 1 answers fast, 2 answers late, 3 holds high early
	always_ff @(posedge clk_sys) begin
		if (reset || hold_mode == 2'h0) begin
			cnt <= 0;
			power_hold <= 1'b0;
		end else if (hold_mode == 2'h3) begin
			power_hold <= 1'b1;
		end else if (!wake_level_n) begin
			cnt <= cnt + 1;
			if (cnt >= ((hold_mode == 2'h1) ? 2 : 12)) begin
				power_hold <= 1'b1;
			end
		end
	end
endmodule

// >>> tb/pmic_supervisor_monitor.sv
`timescale 1ns/10ps
module pmic_supervisor_monitor #(
	parameter int unsigned GOOD_RELEASE_CYCLES = 6,
	parameter int unsigned WAKE_DELAY_CYCLES = 8,
	parameter int unsigned HOLD_TIMEOUT_CYCLES = 30,
	parameter int unsigned HARD_RESET_MIN_CYCLES = 10
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic power_hold_in,
	input wire logic hard_reset_in_n,
	input wire logic ac_valid_in,
	input wire logic usb_valid_in,
	input wire logic ac_below_4v1_in,
	input wire logic seq_done_in,
	input wire logic seq_power_up,
	input wire logic rails_force_off,
	input wire pmic_supervisor_pkg::power_state_t power_state,
	input wire pmic_supervisor_pkg::source_t source_select,
	input wire logic linear_rails_good_out,
	input wire logic main_rails_good_out,
	input wire logic wake_notify_n_oe,
	input wire logic irq_out_n_oe
);
	import pmic_supervisor_pkg::*;
	int rel_cnt;
	int wait_cnt;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	always_ff @(posedge clk_sys) begin
		if (reset || power_state != ST_ACTIVE || !seq_done_in) begin
			rel_cnt <= 0;
		end else if (rel_cnt < 1000) begin
			rel_cnt <= rel_cnt + 1;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (reset || power_state != ST_WAIT_HOLD) begin
			wait_cnt <= 0;
		end else if (wait_cnt < 1000) begin
			wait_cnt <= wait_cnt + 1;
		end
	end
	sequence s_wake_quiet;
		(!wake_notify_n_oe) [*6];
	endsequence
	a_lin_good_off: assert property ((power_state inside {ST_OFF, ST_HARD_RESET}) [*2] |-> !linear_rails_good_out)
		else $error("linear good high while off");
	a_main_good_low: assert property ((power_state inside {ST_SLEEP, ST_WAIT_HOLD}) [*2] |-> !main_rails_good_out)
		else $error("main good high while not active");
	a_main_good_delay: assert property ($rose(main_rails_good_out) |-> rel_cnt >= GOOD_RELEASE_CYCLES - 1)
		else $error("main good rose early");
	a_wake_released: assert property ((power_state == ST_ACTIVE) [*2] |-> !wake_notify_n_oe)
		else $error("wake pin low in active");
	a_wake_delay: assert property ($rose(power_state == ST_WAIT_HOLD) |-> s_wake_quiet ##[1:6] wake_notify_n_oe)
		else $error("wake pin delay wrong");
	a_hold_timeout: assert property (wait_cnt <= WAKE_DELAY_CYCLES + HOLD_TIMEOUT_CYCLES + 4)
		else $error("hold wait not ended");
	a_sleep_follow: assert property (power_state == ST_ACTIVE && !power_hold_in |-> ##[1:2] power_state != ST_ACTIVE)
		else $error("active kept without hold");
	a_reset_force: assert property (!hard_reset_in_n |=> rails_force_off)
		else $error("rails not forced off");
	a_reset_leave: assert property ($fell(rails_force_off) |->
		power_state == ST_ACTIVE && seq_power_up && $past(rails_force_off, HARD_RESET_MIN_CYCLES))
		else $error("hard reset left wrongly");
	a_irq_rearm: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFFS_IRQ_FLAGS
		|-> ##2 (!irq_out_n_oe) [*6])
		else $error("interrupt not released");
	a_src_ac: assert property ((ac_valid_in && !ac_below_4v1_in) [*3] |-> source_select == SRC_AC)
		else $error("ac not selected");
	a_src_usb: assert property ((!ac_valid_in && usb_valid_in) [*3] |-> source_select == SRC_USB)
		else $error("usb not selected");
endmodule
bind pmic_supervisor_signals pmic_supervisor_monitor #(.GOOD_RELEASE_CYCLES(GOOD_RELEASE_CYCLES),
	.WAKE_DELAY_CYCLES(WAKE_DELAY_CYCLES), .HOLD_TIMEOUT_CYCLES(HOLD_TIMEOUT_CYCLES),
	.HARD_RESET_MIN_CYCLES(HARD_RESET_MIN_CYCLES)) mon (.clk_sys(clk_sys), .reset(reset),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.power_hold_in(power_hold_in), .hard_reset_in_n(hard_reset_in_n), .ac_valid_in(ac_valid_in),
	.usb_valid_in(usb_valid_in), .ac_below_4v1_in(ac_below_4v1_in), .seq_done_in(seq_done_in),
	.seq_power_up(seq_power_up), .rails_force_off(rails_force_off), .power_state(power_state),
	.source_select(source_select), .linear_rails_good_out(linear_rails_good_out),
	.main_rails_good_out(main_rails_good_out), .wake_notify_n_oe(wake_notify_n_oe), .irq_out_n_oe(irq_out_n_oe));

// >>> tb/testbench.sv
`timescale 1ns/10ps
module testbench;
	import pmic_supervisor_pkg::*;
	localparam int DG = 8;
	localparam int WK = 8;
	localparam int HT = 30;
	localparam int HR = 10;
	logic clk_sys = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, rd, v;
	logic [1:0] bresp, rresp, rs, hold_mode = 2'h1, sw_good = 2'h3, lin_en = 2'h1;
	logic awready, wready, bvalid, arready, rvalid, power_hold, seq_up, seq_down, force_off;
	logic button = 1, hard_n = 1, ac = 0, usb = 0, below = 0, seq_done = 0, therm = 0, lin_out, main_out;
	logic wake_oe, irq_oe, wake_out, irq_out;
	battery_t battery = BATT_GOOD;
	power_state_t state;
	source_t src;
	int fails = 0, checks = 0, cycles = 0, n, i;
	logic [31:0] model_reg [5];
	logic [7:0] rw_addr [3] = '{OFFS_GOOD_MASK_CONFIG, OFFS_CONFIG, OFFS_IRQ_MASK};
	pmic_supervisor_signals #(.DEGLITCH_CYCLES(DG), .WAKE_DELAY_CYCLES(WK), .GOOD_RELEASE_CYCLES(6),
		.LONG_PRESS_CYCLES(60), .HOLD_TIMEOUT_CYCLES(HT), .HARD_RESET_MIN_CYCLES(HR)) dut (
		.clk_sys(clk_sys), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .button_in_n(button),
		.power_hold_in(power_hold), .hard_reset_in_n(hard_n), .ac_valid_in(ac), .usb_valid_in(usb),
		.ac_below_4v1_in(below), .battery_state_in(battery), .buck_good_in(3'h7),
		.switchable_good_in(sw_good), .linear_enabled_in(lin_en), .linear_good_in(2'h1),
		.seq_done_in(seq_done), .thermal_shutdown_in(therm), .seq_power_up(seq_up),
		.seq_power_down(seq_down), .rails_force_off(force_off), .power_state(state), .source_select(src),
		.linear_rails_good_out(lin_out), .main_rails_good_out(main_out), .wake_notify_n_in(!wake_oe),
		.wake_notify_n_out(wake_out), .wake_notify_n_oe(wake_oe), .irq_out_n_in(!irq_oe),
		.irq_out_n_out(irq_out), .irq_out_n_oe(irq_oe));
	host_model host (.clk_sys(clk_sys), .reset(reset), .wake_level_n(!wake_oe), .hold_mode(hold_mode),
		.power_hold(power_hold));
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			complete_run();
		end
	end
	function automatic logic [31:0] wmask(input logic [7:0] a);
		return (a == OFFS_GOOD_MASK_CONFIG) ? 32'h3 : (a == OFFS_CONFIG) ? 32'h7 : (a == OFFS_IRQ_MASK) ? 32'hf : 32'h0;
	endfunction
	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_go, w_go, done;
		done = 0;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!done) begin
			@(negedge clk_sys);
			aw_go = awvalid && awready;
			w_go = wvalid && wready;
			done = bvalid;
			rs = bresp;
			@(posedge clk_sys);
			if (aw_go) awvalid <= 0;
			if (w_go) wvalid <= 0;
		end
		bready <= 0;
		check(rs, (wmask(a) != 0) ? RESP_OKAY : RESP_SLVERR);
		if (wmask(a) != 0) model_reg[a >> 2] = d & wmask(a);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		logic done, ar_go;
		done = 0;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		while (!done) begin
			@(negedge clk_sys);
			ar_go = arvalid && arready;
			done = rvalid;
			rd = rdata;
			rs = rresp;
			@(posedge clk_sys);
			if (ar_go) arvalid <= 0;
		end
		rready <= 0;
		check(rs, (a <= OFFS_IRQ_MASK) ? RESP_OKAY : RESP_SLVERR);
		check(rd & m, e & m);
	endtask
	task automatic wait_state(input power_state_t s, input int lim);
		for (n = 0; n < lim && state !== s; n++) @(negedge clk_sys);
		check(32'(state), 32'(s));
		tick(1);
	endtask
	initial begin
		n = $urandom(44);
		model_reg = '{32'h3, 32'h0, 32'h0, 32'h0, 32'h0};
		tick(5);
		reset <= 0;
		for (i = 0; i < 3; i++) rd_chk(rw_addr[i], model_reg[rw_addr[i] >> 2], '1);
		rd_chk(8'h20, 0, '1);
		wr(8'h20, $urandom);
		for (i = 0; i < 3; i++) begin
			wr(rw_addr[i], $urandom);
			rd_chk(rw_addr[i], model_reg[rw_addr[i] >> 2], '1);
		end
		for (i = 0; i < 3; i++) wr(rw_addr[i], (i == 0) ? 32'h3 : 32'h0);
		button <= 0;
		tick(5);
		button <= 1;
		tick(DG + 4);
		check(32'(state), 32'(ST_OFF));
		check(irq_oe, 0);
		button <= 0;
		wait_state(ST_WAIT_HOLD, DG + 6);
		tick(1);
		check(irq_oe, 1);
		for (n = 0; n < WK + 8 && wake_oe !== 1; n++) @(negedge clk_sys);
		check(wake_oe, 1);
		wait_state(ST_ACTIVE, 4 * WK);
		check(wake_oe, 0);
		rd_chk(OFFS_IRQ_FLAGS, 32'h1, '1);
		check(irq_oe, 0);
		rd_chk(OFFS_STATUS, {26'h0, ST_ACTIVE, 3'h1}, 32'h39);
		wr(OFFS_IRQ_MASK, 32'h1);
		button <= 1;
		tick(DG + 4);
		check(irq_oe, 0);
		rd_chk(OFFS_IRQ_FLAGS, 32'h1, '1);
		wr(OFFS_IRQ_MASK, 32'h0);
		check(lin_out, 1);
		seq_done <= 1;
		tick(12);
		check(main_out, 1);
		lin_en <= 2'h0;
		tick(4);
		check(lin_out, 0);
		lin_en <= 2'h1;
		wr(OFFS_CONFIG, 32'h2);
		sw_good <= 2'h2;
		tick(4);
		check(main_out, 1);
		check(32'(state), 32'(ST_ACTIVE));
		sw_good <= 2'h3;
		wr(OFFS_CONFIG, 32'h0);
		for (i = 0; i < 12; i++) begin
			v = $urandom_range(3);
			ac <= v[1];
			usb <= v[0];
			tick(4);
			check(32'(src), v[1] ? 32'(SRC_AC) : v[0] ? 32'(SRC_USB) : 32'(SRC_BATTERY));
		end
		battery <= BATT_DEAD;
		ac <= 1;
		usb <= 1;
		tick(4);
		below <= 1;
		tick(4);
		check(32'(src), 32'(SRC_AC));
		battery <= BATT_SHORT;
		tick(4);
		check(32'(src), 32'(SRC_USB));
		{ac, usb, below} <= 3'h0;
		battery <= BATT_GOOD;
		rd_chk(OFFS_IRQ_FLAGS, 32'h6, 32'h6);
		hold_mode <= 2'h0;
		wait_state(ST_SLEEP, 6);
		tick(1);
		check(main_out, 0);
		check(lin_out, 1);
		hold_mode <= 2'h3;
		wait_state(ST_ACTIVE, 6);
		button <= 0;
		wait_state(ST_CYCLE, DG + 72);
		wait_state(ST_ACTIVE, 4 * WK);
		button <= 1;
		tick(DG + 4);
		wr(OFFS_CONFIG, 32'h1);
		for (i = 0; i < 2; i++) begin
			hold_mode <= 2'(i * 2);
			wait_state(i ? ST_OFF : ST_SLEEP, 6);
			button <= 0;
			wait_state(ST_WAIT_HOLD, DG + 6);
			button <= 1;
			wait_state(i ? ST_ACTIVE : ST_OFF, WK + HT + 8);
			if (i == 0) check(n > HT, 1);
		end
		therm <= 1;
		wait_state(ST_OFF, 4);
		therm <= 0;
		hard_n <= 0;
		tick(3);
		check(force_off, 1);
		check(lin_out, 0);
		hard_n <= 1;
		wait_state(ST_ACTIVE, HR + 6);
		check(n + 3 >= HR, 1);
		rd_chk(OFFS_CONFIG, 32'h0, '1);
		complete_run();
	end
endmodule

// >>> verilog/pmic_supervisor_signals.sv
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
module pmic_supervisor_signals #(
	parameter int unsigned DEGLITCH_CYCLES = pmic_supervisor_pkg::DEGLITCH_CYCLES,
	parameter int unsigned WAKE_DELAY_CYCLES = pmic_supervisor_pkg::WAKE_DELAY_CYCLES,
	parameter int unsigned GOOD_RELEASE_CYCLES = pmic_supervisor_pkg::GOOD_RELEASE_CYCLES,
	parameter int unsigned LONG_PRESS_CYCLES = pmic_supervisor_pkg::LONG_PRESS_CYCLES,
	parameter int unsigned HOLD_TIMEOUT_CYCLES = pmic_supervisor_pkg::HOLD_TIMEOUT_CYCLES,
	parameter int unsigned HARD_RESET_MIN_CYCLES = pmic_supervisor_pkg::HARD_RESET_MIN_CYCLES
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic button_in_n,
	input wire logic power_hold_in,
	input wire logic hard_reset_in_n,
	input wire logic ac_valid_in,
	input wire logic usb_valid_in,
	input wire logic ac_below_4v1_in,
	input wire pmic_supervisor_pkg::battery_t battery_state_in,
	input wire logic [2:0] buck_good_in,
	input wire logic [1:0] switchable_good_in,
	input wire logic [1:0] linear_enabled_in,
	input wire logic [1:0] linear_good_in,
	input wire logic seq_done_in,
	input wire logic thermal_shutdown_in,
	output logic seq_power_up,
	output logic seq_power_down,
	output logic rails_force_off,
	output pmic_supervisor_pkg::power_state_t power_state,
	output pmic_supervisor_pkg::source_t source_select,
	output logic linear_rails_good_out,
	output logic main_rails_good_out,
	input wire logic wake_notify_n_in,
	output logic wake_notify_n_out,
	output logic wake_notify_n_oe,
	input wire logic irq_out_n_in,
	output logic irq_out_n_out,
	output logic irq_out_n_oe
);
	import pmic_supervisor_pkg::*;

	function automatic logic is_mapped(input logic [7:0] addr);
		is_mapped = (addr == OFFS_GOOD_MASK_CONFIG) || (addr == OFFS_CONFIG) || (addr == OFFS_STATUS) ||
			(addr == OFFS_IRQ_FLAGS) || (addr == OFFS_IRQ_MASK);
	endfunction

	logic [1:0] good_mask_config;
	logic [2:0] config_bits;
	logic [3:0] irq_mask;
	logic [3:0] irq_flags;
	logic [11:0] rearm_cnt;
	logic [7:0] aw_addr;
	logic aw_full;
	logic [31:0] w_data;
	logic w_strb0;
	logic w_full;
	logic do_write;
	logic rd_clear;
	logic [31:0] read_word;
	logic regs_default;

	logic button_stable;
	logic [31:0] deglitch_cnt;
	logic button_press;
	logic button_change;
	logic [31:0] long_cnt;
	logic long_press;
	logic ac_prev;
	logic usb_prev;
	logic ac_change;
	logic usb_change;
	logic wake_event;

	power_state_t next_state;
	logic [31:0] wait_cnt;
	logic [31:0] hold_cnt;
	logic [31:0] hr_cnt;
	logic [31:0] release_cnt;
	logic good_released;
	logic rails_ok;
	logic fault_cond;
	logic fault_event;
	logic linear_ok;
	logic [3:0] irq_events;
	logic [3:0] irq_persist;
	source_t next_source;

	// Registers return to defaults on bus reset and throughout a hard reset
	assign regs_default = reset || (power_state == ST_HARD_RESET);

	// AXI4-Lite write path: address and data taken independently
	assign s_axi_awready = !aw_full;
	assign s_axi_wready = !w_full;
	assign do_write = aw_full && w_full && !s_axi_bvalid;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			aw_full <= 1'b0;
			aw_addr <= 8'h00;
		end else if (s_axi_awvalid && !aw_full) begin
			aw_full <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (do_write) begin
			aw_full <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			w_full <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb0 <= 1'b0;
		end else if (s_axi_wvalid && !w_full) begin
			w_full <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb0 <= s_axi_wstrb[0];
		end else if (do_write) begin
			w_full <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (regs_default) begin
			good_mask_config <= GOOD_MASK_RESET;
			config_bits <= CONFIG_RESET;
			irq_mask <= IRQ_MASK_RESET;
		end else if (do_write && w_strb0) begin
			if (aw_addr == OFFS_GOOD_MASK_CONFIG) begin
				good_mask_config <= w_data[1:0];
			end
			if (aw_addr == OFFS_CONFIG) begin
				config_bits <= w_data[2:0];
			end
			if (aw_addr == OFFS_IRQ_MASK) begin
				irq_mask <= w_data[3:0];
			end
		end
	end

	// AXI4-Lite read path; reading the flag register clears it
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_clear = s_axi_arvalid && !s_axi_rvalid && (s_axi_araddr == OFFS_IRQ_FLAGS);

	always_comb begin
		read_word = 32'h0000_0000;
		case (s_axi_araddr)
			OFFS_GOOD_MASK_CONFIG: read_word[1:0] = good_mask_config;
			OFFS_CONFIG: read_word[2:0] = config_bits;
			OFFS_STATUS: read_word[11:0] = {linear_rails_good_out, main_rails_good_out, irq_out_n_in,
				wake_notify_n_in, source_select, power_state, usb_valid_in, ac_valid_in, !button_stable};
			OFFS_IRQ_FLAGS: read_word[3:0] = irq_flags;
			OFFS_IRQ_MASK: read_word[3:0] = irq_mask;
			default: read_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= read_word;
			s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Button deglitch on the free-running clock; level must hold for the full window
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			button_stable <= 1'b1;
			deglitch_cnt <= 32'h0000_0000;
		end else if (button_in_n == button_stable) begin
			deglitch_cnt <= 32'h0000_0000;
		end else if (deglitch_cnt >= 32'(DEGLITCH_CYCLES - 1)) begin
			button_stable <= button_in_n;
			deglitch_cnt <= 32'h0000_0000;
		end else begin
			deglitch_cnt <= deglitch_cnt + 32'h0000_0001;
		end
	end

	assign button_change = (button_in_n != button_stable) && (deglitch_cnt >= 32'(DEGLITCH_CYCLES - 1));
	assign button_press = button_change && button_stable;

	// Long-press counter fires once per press
	always_ff @(posedge clk_sys) begin
		if (reset || button_stable) begin
			long_cnt <= 32'h0000_0000;
		end else if (long_cnt <= 32'(LONG_PRESS_CYCLES)) begin
			long_cnt <= long_cnt + 32'h0000_0001;
		end
	end

	assign long_press = (long_cnt == 32'(LONG_PRESS_CYCLES));

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ac_prev <= 1'b0;
			usb_prev <= 1'b0;
		end else begin
			ac_prev <= ac_valid_in;
			usb_prev <= usb_valid_in;
		end
	end

	assign ac_change = ac_valid_in != ac_prev;
	assign usb_change = usb_valid_in != usb_prev;
	assign wake_event = button_press || (ac_valid_in && !ac_prev) || (usb_valid_in && !usb_prev);

	// Rail health; load-switch outputs drop out of the monitored set
	assign linear_ok = (linear_enabled_in[0] || linear_enabled_in[1]) &&
		!(linear_enabled_in[0] && !linear_good_in[0]) && !(linear_enabled_in[1] && !linear_good_in[1]);
	assign rails_ok = (&buck_good_in) &&
		(switchable_good_in[0] || config_bits[CFG_SW1_LOAD_SWITCH]) &&
		(switchable_good_in[1] || config_bits[CFG_SW2_LOAD_SWITCH]) &&
		(linear_good_in[0] || good_mask_config[0]) &&
		(linear_good_in[1] || good_mask_config[1]);
	assign fault_cond = thermal_shutdown_in || (good_released && !rails_ok);
	assign fault_event = fault_cond && (power_state == ST_ACTIVE || power_state == ST_WAIT_HOLD);

	always_ff @(posedge clk_sys) begin
		if (reset || power_state != ST_ACTIVE || !seq_done_in) begin
			release_cnt <= 32'h0000_0000;
		end else if (release_cnt < 32'(GOOD_RELEASE_CYCLES)) begin
			release_cnt <= release_cnt + 32'h0000_0001;
		end
	end

	assign good_released = (power_state == ST_ACTIVE) && seq_done_in &&
		(release_cnt == 32'(GOOD_RELEASE_CYCLES));

	// Power state machine
	always_comb begin
		next_state = power_state;
		case (power_state)
			ST_OFF, ST_SLEEP: begin
				if (wake_event) begin
					next_state = ST_WAIT_HOLD;
				end else if (power_state == ST_SLEEP && power_hold_in) begin
					next_state = ST_ACTIVE;
				end
			end
			ST_WAIT_HOLD: begin
				if (fault_event) begin
					next_state = ST_OFF;
				end else if (long_press) begin
					next_state = ST_CYCLE;
				end else if (hold_cnt >= 32'(WAKE_DELAY_CYCLES)) begin
					next_state = ST_ACTIVE;
				end else if (!power_hold_in && wait_cnt >= 32'(WAKE_DELAY_CYCLES + HOLD_TIMEOUT_CYCLES)) begin
					next_state = config_bits[CFG_OFF_SELECT] ? ST_OFF : ST_SLEEP;
				end
			end
			ST_ACTIVE: begin
				if (fault_event) begin
					next_state = ST_OFF;
				end else if (long_press) begin
					next_state = ST_CYCLE;
				end else if (!power_hold_in) begin
					next_state = ST_SLEEP;
				end
			end
			ST_HARD_RESET: begin
				if (hard_reset_in_n && hr_cnt >= 32'(HARD_RESET_MIN_CYCLES)) begin
					next_state = ST_ACTIVE;
				end
			end
			ST_CYCLE: next_state = ST_WAIT_HOLD;
			default: next_state = ST_OFF;
		endcase
		if (!hard_reset_in_n) begin
			next_state = ST_HARD_RESET;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			power_state <= ST_OFF;
			seq_power_up <= 1'b0;
			seq_power_down <= 1'b0;
			rails_force_off <= 1'b0;
		end else begin
			power_state <= next_state;
			seq_power_up <= (next_state == ST_WAIT_HOLD && power_state != ST_WAIT_HOLD) ||
				(next_state == ST_ACTIVE && (power_state == ST_HARD_RESET || power_state == ST_SLEEP));
			seq_power_down <= (power_state == ST_ACTIVE || power_state == ST_WAIT_HOLD) &&
				(next_state == ST_OFF || next_state == ST_SLEEP || next_state == ST_CYCLE);
			rails_force_off <= (next_state == ST_HARD_RESET);
		end
	end

	// Wait counters: time since the wake event, and how long hold has been seen
	always_ff @(posedge clk_sys) begin
		if (reset || power_state != ST_WAIT_HOLD) begin
			wait_cnt <= 32'h0000_0000;
		end else if (wait_cnt < 32'(WAKE_DELAY_CYCLES + HOLD_TIMEOUT_CYCLES)) begin
			wait_cnt <= wait_cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset || power_state != ST_WAIT_HOLD || !power_hold_in || wait_cnt < 32'(WAKE_DELAY_CYCLES)) begin
			hold_cnt <= 32'h0000_0000;
		end else if (hold_cnt < 32'(WAKE_DELAY_CYCLES)) begin
			hold_cnt <= hold_cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset || power_state != ST_HARD_RESET) begin
			hr_cnt <= 32'h0000_0000;
		end else if (hr_cnt < 32'(HARD_RESET_MIN_CYCLES)) begin
			hr_cnt <= hr_cnt + 32'h0000_0001;
		end
	end

	// Rail-good pins
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			linear_rails_good_out <= 1'b0;
			main_rails_good_out <= 1'b0;
		end else begin
			linear_rails_good_out <= linear_ok && (power_state != ST_OFF) &&
				(power_state != ST_HARD_RESET);
			main_rails_good_out <= good_released && rails_ok;
		end
	end

	// Input source selection
	always_comb begin
		if (ac_valid_in && !(ac_below_4v1_in && usb_valid_in && (battery_state_in == BATT_SHORT ||
			(battery_state_in == BATT_DEAD && source_select != SRC_AC)))) begin
			next_source = SRC_AC;
		end else if (usb_valid_in) begin
			next_source = SRC_USB;
		end else begin
			next_source = SRC_BATTERY;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			source_select <= SRC_BATTERY;
		end else begin
			source_select <= next_source;
		end
	end

	// Interrupt flags: a new event wins over a clearing read
	assign irq_events[IRQ_BUTTON] = button_change;
	assign irq_events[IRQ_AC] = ac_change;
	assign irq_events[IRQ_USB] = usb_change;
	assign irq_events[IRQ_FAULT] = fault_event;
	assign irq_persist = {fault_cond, 3'b000};

	generate
		for (genvar i = 0; i < 4; i++) begin : gen_flag
			always_ff @(posedge clk_sys) begin
				if (regs_default) begin
					irq_flags[i] <= 1'b0;
				end else if (irq_events[i] || (rd_clear && irq_persist[i])) begin
					irq_flags[i] <= 1'b1;
				end else if (rd_clear) begin
					irq_flags[i] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rearm_cnt <= 12'h000;
		end else if (rd_clear) begin
			rearm_cnt <= IRQ_REARM_CYCLES;
		end else if (rearm_cnt != 12'h000) begin
			rearm_cnt <= rearm_cnt - 12'h001;
		end
	end

	// Open-drain pins: value low, enable high when pulling down
	assign wake_notify_n_out = 1'b0;
	assign irq_out_n_out = 1'b0;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			irq_out_n_oe <= 1'b0;
			wake_notify_n_oe <= 1'b0;
		end else begin
			irq_out_n_oe <= (|(irq_flags & ~irq_mask)) && !rd_clear && (rearm_cnt == 12'h000);
			wake_notify_n_oe <= (next_state == ST_WAIT_HOLD) && (wait_cnt >= 32'(WAKE_DELAY_CYCLES));
		end
	end
endmodule
